/* File: verilog/adcseq_pkg.sv */
// Package of constants for the conversion sequencer
`default_nettype none
package adcseq_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] ADDR_CTRL0  = 4'h0;
  localparam logic [3:0] ADDR_CTRL1  = 4'h1;
  localparam logic [3:0] ADDR_RESHI  = 4'h2;
  localparam logic [3:0] ADDR_RESLO  = 4'h3;
  localparam logic [3:0] ADDR_ISTAT  = 4'h4;
  localparam logic [3:0] ADDR_IMASK  = 4'h5;
  localparam logic [3:0] ADDR_SAMPLE = 4'h6;
  // ==========================================================
  // Field positions in control register 0
  localparam int BIT_START  = 7;
  localparam int BIT_BUSY   = 6;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_FORMAT = 4;
  // Field positions in control register 1
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 2;
  // Interrupt status bit for conversion done
  localparam int BIT_DONE = 0;
  // ==========================================================
  // Reset values
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] RES_RST   = 8'h00;
  // ==========================================================
  // Conversion timing in conversion clock cycles, divider counter and result widths
  localparam logic [4:0] SAMPLE_CYCLES = 5'h04;
  localparam logic [4:0] TOTAL_CYCLES  = 5'h10;
  localparam int         DIV_WIDTH     = 7;
  localparam int         RESULT_WIDTH  = 12;
  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ADCSEQ_IDLE   = 3'b001,
    ADCSEQ_SAMPLE = 3'b010,
    ADCSEQ_CONV   = 3'b100
  } adcseq_state_t;
endpackage
`default_nettype wire

/* File: verilog/adcseq_top.sv */
// Conversion sequencer of a successive-approximation converter
//
// Local design decisions: the register addresses and strobed register access.
`default_nettype none
// Overview of operation
// RULE_01: Start bit written high then low launches exactly one conversion.
// RULE_02: Start bit held high resets converter and forces busy flag to zero.
// RULE_03: Busy flag set by hardware once a conversion is launched.
// RULE_04: Busy flag cleared when the running conversion finishes.
// RULE_05: Completion sets the interrupt request flag regardless of enable.
// RULE_06: Enabled completion request drives the interrupt output.
// RULE_07: Without interrupt, software polls busy flag until it reads zero.
// RULE_08: Conversion clock comes only from system clock, divided up to 128.
// RULE_09: Software keeps conversion clock period between 0.5 and 10 us.
// RULE_10: At 4 MHz software avoids divider settings 000, 110 and 111.
// RULE_11: Divider select n divides system clock by two to the power n.
// RULE_12: Conversion lasts 16 conversion clocks: 4 sampling, 12 converting.
// RULE_13: Converter disabled: powered down, result registers keep contents.
// RULE_14: Format 0 left-justifies the 12-bit result, format 1 right-justifies.
// RULE_15: Start bit edges found synchronously; rising edge aborts a conversion.
// RULE_16: Divider is a free-running counter giving a one-cycle enable pulse.
module adcseq_top
  import adcseq_pkg::*;
#(
  parameter int RES_W = RESULT_WIDTH
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [3:0]       regAddr,
  input  wire logic [7:0]       regWdata,
  input  wire logic             regWrite,
  input  wire logic             regRead,
  output logic      [7:0]       regRdata,
  input  wire logic [RES_W-1:0] anaResult,
  output logic                  anaPowerOn,
  output logic                  anaReset,
  output logic                  anaSample,
  output logic                  anaConvTick,
  output logic                  irqOut
);

  // ==========================================================
  // Register storage
  logic                 startBit_q;
  logic                 startPrev_q;
  logic                 enable_q;
  logic                 format_q;
  logic [DIV_MSB:0]     divSel_q;
  logic [RES_W-1:0]     result_q;
  logic                 irqStat_q;
  logic                 irqMask_q;
  logic                 busy_q;
  adcseq_state_t        state_q;
  logic [4:0]           cycCnt_q;
  logic [DIV_WIDTH-1:0] divCnt_q;
  logic                 tick;
  logic                 startRise;
  logic                 startFall;
  logic                 convDone;
  logic [15:0]          resPacked;

  // Control writes; start bit kept as written so a held high level resets
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      startBit_q <= 1'b0;
      enable_q   <= 1'b0;
      format_q   <= 1'b0;
      divSel_q   <= '0;
      irqMask_q  <= 1'b0;
    end else if (regWrite) begin
      case (regAddr)
        ADDR_CTRL0: begin
          startBit_q <= regWdata[BIT_START];
          enable_q   <= regWdata[BIT_ENABLE];
          format_q   <= regWdata[BIT_FORMAT];
        end
        ADDR_CTRL1: divSel_q  <= regWdata[DIV_MSB:DIV_LSB];
        ADDR_IMASK: irqMask_q <= regWdata[BIT_DONE];
        default:    ;
      endcase
    end
  end

  // ==========================================================
  // Start edge detection on the registered bit
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      startPrev_q <= 1'b0;
    end else begin
      startPrev_q <= startBit_q; // [RULE_15]
    end
  end
  assign startRise = startBit_q & ~startPrev_q; // [RULE_15]
  assign startFall = ~startBit_q & startPrev_q; // [RULE_01]

  // ==========================================================
  // Conversion clock enable; counter runs free so no gated clock net exists
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 1'b1; // [RULE_16]
    end
  end
  // Pulse whenever the low divSel bits of the counter are all ones
  always_comb begin
    logic [DIV_WIDTH-1:0] lowMask;
    lowMask = DIV_WIDTH'((8'h01 << divSel_q) - 8'h01); // [RULE_11]
    tick = ((divCnt_q & lowMask) == lowMask); // [RULE_08] [RULE_16]
  end

  // ==========================================================
  // Sequencer: 4 sampling ticks, then 12 converting ticks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= ADCSEQ_IDLE;
      cycCnt_q <= '0;
    end else if (startBit_q || !enable_q) begin
      // Held start or power-down keeps converter in reset
      state_q  <= ADCSEQ_IDLE; // [RULE_02] [RULE_15] [RULE_13]
      cycCnt_q <= '0;
    end else begin
      case (state_q)
        ADCSEQ_IDLE: begin
          if (startFall) begin
            state_q  <= ADCSEQ_SAMPLE; // [RULE_01]
            cycCnt_q <= '0;
          end
        end
        ADCSEQ_SAMPLE: begin
          if (tick) begin
            cycCnt_q <= cycCnt_q + 5'h01;
            if (cycCnt_q == SAMPLE_CYCLES - 5'h01) begin
              state_q <= ADCSEQ_CONV; // [RULE_12]
            end
          end
        end
        ADCSEQ_CONV: begin
          if (tick) begin
            cycCnt_q <= cycCnt_q + 5'h01;
            if (cycCnt_q == TOTAL_CYCLES - 5'h01) begin
              state_q <= ADCSEQ_IDLE; // [RULE_12]
            end
          end
        end
        default: state_q <= ADCSEQ_IDLE;
      endcase
    end
  end
  assign convDone = (state_q == ADCSEQ_CONV) && tick && (cycCnt_q == TOTAL_CYCLES - 5'h01)
                    && !startBit_q && enable_q;

  // ==========================================================
  // Busy flag follows launch and completion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
    end else if (startBit_q || !enable_q) begin
      busy_q <= 1'b0; // [RULE_02]
    end else if (state_q == ADCSEQ_IDLE && startFall) begin
      busy_q <= 1'b1; // [RULE_03]
    end else if (convDone) begin
      busy_q <= 1'b0; // [RULE_04] [RULE_07]
    end
  end

  // ==========================================================
  // Result capture; nothing is captured while disabled
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= '0;
    end else if (convDone) begin
      result_q <= anaResult; // [RULE_13]
    end
  end
  // Justification applied on read so a format change relabels the old value
  always_comb begin
    if (format_q) begin
      resPacked = {4'h0, result_q}; // [RULE_14]
    end else begin
      resPacked = {result_q, 4'h0}; // [RULE_14]
    end
  end

  // ==========================================================
  // Sticky done flag; a new completion wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_q <= 1'b0;
    end else if (convDone) begin
      irqStat_q <= 1'b1; // [RULE_05]
    end else if (regWrite && regAddr == ADDR_ISTAT && regWdata[BIT_DONE]) begin
      irqStat_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= (irqStat_q | convDone) & irqMask_q; // [RULE_06]
    end
  end

  // ==========================================================
  // Read port: data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        ADDR_CTRL0:  regRdata <= {startBit_q, busy_q, enable_q, format_q, 4'h0};
        ADDR_CTRL1:  regRdata <= {5'h00, divSel_q};
        ADDR_RESHI:  regRdata <= resPacked[15:8];
        ADDR_RESLO:  regRdata <= resPacked[7:0];
        ADDR_ISTAT:  regRdata <= {7'h00, irqStat_q};
        ADDR_IMASK:  regRdata <= {7'h00, irqMask_q};
        ADDR_SAMPLE: regRdata <= {7'h00, state_q == ADCSEQ_SAMPLE};
        default:     regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ==========================================================
  // Analog-side controls, all registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      anaPowerOn  <= 1'b0;
      anaReset    <= 1'b1;
      anaSample   <= 1'b0;
      anaConvTick <= 1'b0;
    end else begin
      anaPowerOn  <= enable_q; // [RULE_13]
      anaReset    <= startBit_q | ~enable_q; // [RULE_02]
      anaSample   <= (state_q == ADCSEQ_SAMPLE);
      anaConvTick <= (state_q != ADCSEQ_IDLE) & tick; // [RULE_08]
    end
  end

  // ==========================================================
  // Checks
  chk_busy_on_launch: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_03]
    (state_q == ADCSEQ_IDLE && startFall && enable_q) |=> busy_q)
    else $error("busy not set after launch");
  chk_busy_held_reset: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_02]
    (startBit_q && startPrev_q) |-> !busy_q)
    else $error("busy set while start held");
  chk_busy_done_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_04]
    convDone |=> !busy_q)
    else $error("busy not cleared at completion");
  chk_irq_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_05]
    convDone |=> irqStat_q)
    else $error("done flag not set");
  chk_irq_out_mask: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_06]
    (irqStat_q && irqMask_q) |=> irqOut)
    else $error("interrupt not raised");
  chk_tick_div_rate: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_11]
    (tick && divSel_q == 3'h1 && $stable(divSel_q)) |=> !tick)
    else $error("divide by two pulses too often");
  chk_result_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    !enable_q |=> $stable(result_q))
    else $error("result changed while disabled");
  chk_rise_abort: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_15]
    startRise |=> state_q == ADCSEQ_IDLE)
    else $error("rising start did not abort");
  chk_conv_length: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_12]
    (state_q == ADCSEQ_IDLE && startFall && enable_q && divSel_q == 3'h0 && !regWrite)
      |=> busy_q [*8] ##1 busy_q [*8] ##1 (!busy_q || startBit_q || !enable_q))
    else $error("conversion not 16 clocks at divide by one");
  cov_conv_done:  cover property (@(posedge clk_sys) disable iff (!rst_n) convDone);
  cov_abort:      cover property (@(posedge clk_sys) disable iff (!rst_n) busy_q && startRise);
  cov_irq:        cover property (@(posedge clk_sys) disable iff (!rst_n) irqOut);
  cov_set_clear:  cover property (@(posedge clk_sys) disable iff (!rst_n)
    convDone && regWrite && regAddr == ADDR_ISTAT);

  // ==========================================================
  // Further checks on flags, pins and the phase counter
  // The counter bounds catch a phase that overruns before the busy flag shows it
  chk_irq_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_05]
    (irqStat_q && !(regWrite && regAddr == ADDR_ISTAT && regWdata[BIT_DONE])) |=> irqStat_q)
    else $error("done flag dropped without a clear");
  chk_irq_low_mask: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_06]
    !irqMask_q |=> !irqOut)
    else $error("interrupt raised while masked");
  chk_irq_no_flag: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_06]
    (!irqStat_q && !convDone) |=> !irqOut)
    else $error("interrupt raised with no flag");
  chk_reset_pin_start: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_02]
    startBit_q |=> anaReset)
    else $error("converter not reset while start high");
  chk_reset_pin_off: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    !enable_q |=> anaReset)
    else $error("converter not reset while disabled");
  chk_power_on_pin: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    enable_q |=> anaPowerOn)
    else $error("converter not powered while enabled");
  chk_power_off_pin: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    !enable_q |=> !anaPowerOn)
    else $error("converter powered while disabled");
  chk_busy_disabled: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    !enable_q |=> !busy_q)
    else $error("busy set while disabled");
  chk_busy_rise_clear: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_02]
    startRise |=> !busy_q)
    else $error("busy not cleared by rising start");
  chk_idle_busy_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_04]
    (state_q == ADCSEQ_IDLE) |-> !busy_q)
    else $error("busy set while sequencer idle");
  chk_launch_sample: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_01]
    (state_q == ADCSEQ_IDLE && startFall && enable_q) |=> state_q == ADCSEQ_SAMPLE)
    else $error("launch did not enter sampling");
  chk_sample_to_conv: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_12]
    (state_q == ADCSEQ_SAMPLE && tick && cycCnt_q == SAMPLE_CYCLES - 5'h01 && !startBit_q && enable_q)
      |=> state_q == ADCSEQ_CONV)
    else $error("sampling did not end after four ticks");
  chk_sample_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_12]
    (state_q == ADCSEQ_SAMPLE) |-> cycCnt_q < SAMPLE_CYCLES)
    else $error("sampling phase overran");
  chk_conv_count: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_12]
    (state_q == ADCSEQ_CONV) |-> (cycCnt_q >= SAMPLE_CYCLES && cycCnt_q < TOTAL_CYCLES))
    else $error("converting phase count out of range");
  chk_sample_pin: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_12]
    (state_q == ADCSEQ_SAMPLE) |=> anaSample)
    else $error("sample pin low during sampling");
  chk_tick_div_one: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_11]
    (divSel_q == 3'h0) |-> tick)
    else $error("undivided clock missed a tick");
  chk_conv_tick_pin: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
    (state_q != ADCSEQ_IDLE && tick) |=> anaConvTick)
    else $error("conversion tick not passed on");
  chk_idle_tick_pin: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_08]
    (state_q == ADCSEQ_IDLE) |=> !anaConvTick)
    else $error("conversion tick while idle");
  chk_result_capture: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_13]
    convDone |=> result_q == $past(anaResult))
    else $error("result not captured at completion");
  chk_fmt_right: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_14]
    format_q |-> resPacked[15:12] == 4'h0)
    else $error("right-justified upper bits not zero");
  chk_fmt_left: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RULE_14]
    !format_q |-> resPacked[3:0] == 4'h0)
    else $error("left-justified lower bits not zero");
  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !regRead |=> regRdata == 8'h00)
    else $error("read data not zero without a read");

endmodule // adcseq_top
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the conversion sequencer
`default_nettype none
module testbench
  import adcseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Stimulus and observation signals
  logic        clk_sys, rst_n, regWrite, regRead;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, d;
  logic [11:0] anaResult;
  logic        anaPowerOn, anaReset, anaSample, anaConvTick, irqOut;
  int          n_fail, tests_run, cyc, len;

  adcseq_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .anaResult(anaResult),
    .anaPowerOn(anaPowerOn), .anaReset(anaReset), .anaSample(anaSample),
    .anaConvTick(anaConvTick), .irqOut(irqOut));

  // ==========================================================
  // Clock and cycle counter used for timing the conversions
  initial clk_sys = 1'b0;
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ==========================================================
  // Compare tasks: one for register bytes, one for single bits such as pin levels
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkPin(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("Checks made: %0d, mismatches: %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Register port: one-cycle strobes, read data in the next cycle only
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 v = regRdata;
  endtask
  // Start pulse high then low; the extra edge lets the busy flag land
  task automatic startConv(input logic fmt);
    wr(ADDR_CTRL0, {3'b101, fmt, 4'h0});
    repeat (2) @(posedge clk_sys);
    #1 chkPin("anaReset start high", 1'b1, anaReset);
    wr(ADDR_CTRL0, {3'b001, fmt, 4'h0});
    len = cyc;
    @(posedge clk_sys);
  endtask
  // Polls busy with a bound; a hang ends the run as a failure
  task automatic waitIdle;
    for (int k = 0; k <= 1500; k++) begin
      rd(ADDR_CTRL0, d);
      if (d[BIT_BUSY] === 1'b0) break;
      if (k == 1500) begin
        n_fail++;
        $display("[ERR] busy flag never cleared");
        give_verdict();
      end
    end
    len = cyc - len;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    logic [11:0] res;
    rst_n = 1'b0; regWrite = 1'b0; regRead = 1'b0; regAddr = 4'h0; regWdata = 8'h00;
    anaResult = 12'h000; cyc = 0; n_fail = 0; tests_run = 0;
    repeat (2) @(posedge clk_sys);
    #1 chkPin("anaReset in reset", 1'b1, anaReset);
    rst_n <= 1'b1;
    // Reset values, and an unmapped place that ignores writes
    wr(4'h7, 8'hFF);
    for (int a = 0; a < 8; a++) begin
      rd(a[3:0], d);
      chk("reset value", 8'h00, d);
    end
    $display("test reset values done");
    // Every divider setting, both formats, interrupt masked and unmasked
    for (int dv = 0; dv < 8; dv++) begin
      res = 12'h5A3 ^ {4{dv[2:0]}};
      anaResult <= res;
      wr(ADDR_IMASK, {7'h00, dv[1]});
      wr(ADDR_CTRL1, {5'h00, dv[2:0]});
      startConv(dv[0]);
      #1 chkPin("anaPowerOn", 1'b1, anaPowerOn);
      if (dv >= 3) begin
        rd(ADDR_SAMPLE, d);
        chk("sampling phase", 8'h01, d);
        chkPin("anaSample", 1'b1, anaSample);
      end
      rd(ADDR_CTRL0, d);
      chkPin("busy after start", 1'b1, d[BIT_BUSY]);
      if (dv == 0) chkPin("anaConvTick", 1'b1, anaConvTick);
      waitIdle();
      chkPin("length in range", 1'b1, len >= (15 << dv) && len <= (16 << dv) + 10);
      rd(ADDR_RESHI, d);
      chk("result high", dv[0] ? {4'h0, res[11:8]} : res[11:4], d);
      rd(ADDR_RESLO, d);
      chk("result low", dv[0] ? res[7:0] : {res[3:0], 4'h0}, d);
      rd(ADDR_ISTAT, d);
      chk("done flag", 8'h01, d);
      chkPin("irqOut", dv[1], irqOut);
      wr(ADDR_ISTAT, 8'h01);
      repeat (3) @(posedge clk_sys);
      #1 chkPin("irqOut cleared", 1'b0, irqOut);
      rd(ADDR_ISTAT, d);
      chk("done flag cleared", 8'h00, d);
      $display("test divider %0d done", dv);
    end
    // Abort by raising start mid-conversion, then launch again
    anaResult <= 12'h123;
    startConv(1'b0);
    wr(ADDR_CTRL0, 8'hA0);
    repeat (2) @(posedge clk_sys);
    rd(ADDR_CTRL0, d);
    chkPin("busy on abort", 1'b0, d[BIT_BUSY]);
    chkPin("anaReset on abort", 1'b1, anaReset);
    repeat (2100) @(posedge clk_sys);
    rd(ADDR_ISTAT, d);
    chk("no done after abort", 8'h00, d);
    wr(ADDR_CTRL0, 8'h20);
    len = cyc;
    @(posedge clk_sys);
    waitIdle();
    rd(ADDR_ISTAT, d);
    chk("done after relaunch", 8'h01, d);
    wr(ADDR_ISTAT, 8'h01);
    $display("test abort done");
    // Disabled converter: no conversion, results kept
    anaResult <= 12'hFFF;
    wr(ADDR_CTRL0, 8'h80);
    wr(ADDR_CTRL0, 8'h00);
    repeat (40) @(posedge clk_sys);
    rd(ADDR_CTRL0, d);
    chkPin("busy while disabled", 1'b0, d[BIT_BUSY]);
    chkPin("anaPowerOn off", 1'b0, anaPowerOn);
    chkPin("anaSample off", 1'b0, anaSample);
    chkPin("anaConvTick off", 1'b0, anaConvTick);
    rd(ADDR_RESHI, d);
    chk("result high kept", 8'h12, d);
    rd(ADDR_RESLO, d);
    chk("result low kept", 8'h30, d);
    rd(ADDR_ISTAT, d);
    chk("no done while disabled", 8'h00, d);
    $display("test disabled done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
